// ===== shared/aperture_consts.vh
// Constants for the host memory-space decode block.
// Assumes an 8-bit indexed register port and a 24-bit host address bus.
`ifndef APERTURE_CONSTS_VH
`define APERTURE_CONSTS_VH

`define IDX_MAP_CTRL      8'h14
`define IDX_RESP_EN       8'h15
`define MAP_CTRL_RESET    8'h00
`define MAP_CTRL_MASK     8'h1D
`define RESP_EN_RESET     8'h00
`define RESP_EN_MASK      8'hC0
`define MAP_EN_BIT        0
`define SIZE_LSB          2
`define SIZE_MSB          4
`define GFX_EN_BIT        6
`define REGWIN_EN_BIT     7
`define VGA_A_BASE        24'h0A0000
`define VGA_A_LIMIT       24'h0BFFFF
`define VGA_A64_LIMIT     24'h0AFFFF
`define VGA_B0_BASE       24'h0B0000
`define VGA_B0_LIMIT      24'h0B7FFF
`define VGA_B8_BASE       24'h0B8000
`define VGA_B8_LIMIT      24'h0BFFFF

`endif

// ===== hdl/memory_aperture_decode.v
// Host memory-space decode control: two indexed registers plus window decode.
// Assumes host cycle inputs are synchronous to clk; aperture base comes from elsewhere.
// Function
// - Mapping bit 0 set selects decoding through the linear aperture at its base.
// - Mapping bit 0 clear selects legacy windows at A0000/B0000/B8000 per graphics reg 6.
// - Size codes 000..011 select 256K, 512K, 1M, 2M; 11x reserved.
// - Size code 100 selects 4M, code 101 selects 8M.
// - Size field has no effect while mapping bit 0 is zero.
// - Mapping register resets to 00h; bit 1 and bits 7..5 reserved.
// - Enable bit 6 gates response to graphics memory accesses.
// - Enable bit 7 gates response to register window space accesses.
// - Enable bits 5..0 reserved and do not affect decoding.
`timescale 1ns/1ps
`include "aperture_consts.vh"

module memory_aperture_decode #(
   parameter ADDR_W = 24,                  // host memory address width
   parameter REGWIN_SIZE_LOG2 = 16         // log2 of register window space size
) (
   input  wire              clk,            // 40 MHz bus clock
   input  wire              arst_n,         // asynchronous reset, active low
   input  wire              idx_wr,         // write strobe to the index port
   input  wire              data_wr,        // write strobe to the data port
   input  wire              data_rd,        // read strobe on the data port
   input  wire [7:0]        wdata,          // write data for index or data port
   output reg  [7:0]        rdata,          // read data of indexed register
   output reg               rd_hit,         // rdata valid for a mapped index
   input  wire [1:0]        legacy_sel,     // graphics register 6 bits 3..2
   input  wire [ADDR_W-1:0] aperture_base,  // linear aperture base address
   input  wire [ADDR_W-1:0] regwin_base,    // register window space base
   input  wire              mem_cycle,      // host memory cycle present
   input  wire [ADDR_W-1:0] mem_addr,       // host memory address
   output reg               claim_gfx,      // cycle claimed for graphics memory
   output reg               claim_regwin,   // cycle claimed for register window
   output reg               map_linear,     // linear aperture mode active
   output reg  [3:0]        aper_log2_256k  // aperture size exponent over 256K
);

   ////////////////////////////////////////////////////////////////////////////
   reg  [1:0]        rst_sync_r;
   wire              rst_n;
   reg  [7:0]        index_r;
   reg  [7:0]        map_ctrl_r;
   reg  [7:0]        resp_en_r;
   reg  [7:0]        rdata_nxt;
   reg               in_gfx;
   reg               in_regwin;
   wire [2:0]        size_code;
   wire              map_wr_en;
   wire              resp_wr_en;
   wire              idx_known;

   // Reset values and writable-bit masks of the two mapped registers.
   localparam [7:0] MAP_RST   = `MAP_CTRL_RESET;
   localparam [7:0] MAP_KEEP  = `MAP_CTRL_MASK;
   localparam [7:0] RESP_RST  = `RESP_EN_RESET;
   localparam [7:0] RESP_KEEP = `RESP_EN_MASK;

   // Only the second flop feeds the design, so a late release edge cannot
   // reach part of the logic one cycle before the rest.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         rst_sync_r <= 2'h0;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   ////////////////////////////////////////////////////////////////////////////
   // Index match, shared by the write enables and the read hit.
   function idx_is;
      input [7:0] idx;
      input [7:0] target;
      begin
         idx_is = (idx == target);
      end
   endfunction

   // Returns the address mask of a size code; reserved codes give the all-ones mask.
   // Codes 110 and 111 fall to the default and are refused by the caller.
   function [ADDR_W-1:0] size_mask;
      input [2:0] code;
      begin
         case (code)
            3'h0: size_mask = {{(ADDR_W-18){1'b0}}, 18'h3FFFF};
            3'h1: size_mask = {{(ADDR_W-19){1'b0}}, 19'h7FFFF};
            3'h2: size_mask = {{(ADDR_W-20){1'b0}}, 20'hFFFFF};
            3'h3: size_mask = {{(ADDR_W-21){1'b0}}, 21'h1FFFFF};
            3'h4: size_mask = {{(ADDR_W-22){1'b0}}, 22'h3FFFFF};
            3'h5: size_mask = {{(ADDR_W-23){1'b0}}, 23'h7FFFFF};
            default: size_mask = {ADDR_W{1'b1}};
         endcase
      end
   endfunction

   // True when an address lies inside the linear aperture of a size code.
   // The base is compared above the mask only, so an unaligned base is
   // treated as if its low bits were zero.
   function aper_hit;
      input [2:0]        code;
      input [ADDR_W-1:0] addr;
      input [ADDR_W-1:0] base;
      reg   [ADDR_W-1:0] mask;
      begin
         mask     = size_mask(code);
         aper_hit = (code[2:1] != 2'h3) && ((addr & ~mask) == (base & ~mask));
      end
   endfunction

   // Legacy window match for the graphics select field.
   // Select 0 spans both 64K halves, 1 only the lower half, 2 and 3 the two
   // text windows.
   function legacy_hit;
      input [1:0]        sel;
      input [ADDR_W-1:0] addr;
      begin
         case (sel)
            2'h0: legacy_hit = addr >= `VGA_A_BASE && addr <= `VGA_A_LIMIT;
            2'h1: legacy_hit = addr >= `VGA_A_BASE && addr <= `VGA_A64_LIMIT;
            2'h2: legacy_hit = addr >= `VGA_B0_BASE && addr <= `VGA_B0_LIMIT;
            2'h3: legacy_hit = addr >= `VGA_B8_BASE && addr <= `VGA_B8_LIMIT;
            default: legacy_hit = 1'b0;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // The index register is write-only, so it needs no mask.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         index_r <= 8'h00;
      else if (idx_wr)
         index_r <= wdata;
   end

   assign map_wr_en  = data_wr && idx_is(index_r, `IDX_MAP_CTRL);
   assign resp_wr_en = data_wr && idx_is(index_r, `IDX_RESP_EN);
   assign idx_known  = idx_is(index_r, `IDX_MAP_CTRL) || idx_is(index_r, `IDX_RESP_EN);

   // One flop per bit. A reserved bit is never loaded, so it always reads as
   // its reset value and software cannot park data there.
   genvar gb;
   generate
      for (gb = 0; gb < 8; gb = gb + 1) begin : g_reg_bit
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               map_ctrl_r[gb] <= MAP_RST[gb];
               resp_en_r[gb]  <= RESP_RST[gb];
            end else begin
               if (map_wr_en && MAP_KEEP[gb])
                  map_ctrl_r[gb] <= wdata[gb];
               if (resp_wr_en && RESP_KEEP[gb])
                  resp_en_r[gb] <= wdata[gb];
            end
         end
      end
   endgenerate

   always @* begin
      case (index_r)
         `IDX_MAP_CTRL: rdata_nxt = map_ctrl_r;
         `IDX_RESP_EN:  rdata_nxt = resp_en_r;
         default:       rdata_nxt = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   assign size_code = map_ctrl_r[`SIZE_MSB:`SIZE_LSB];

   always @* begin
      in_gfx = 1'b0;
      if (map_ctrl_r[`MAP_EN_BIT]) begin
         // Reserved size codes open no window rather than the whole space.
         in_gfx = aper_hit(size_code, mem_addr, aperture_base);
      end else begin
         // Size field is ignored here; only the legacy select counts.
         in_gfx = legacy_hit(legacy_sel, mem_addr);
      end
      // The register window is always decoded; its enable bit alone gates it.
      in_regwin = (mem_addr >> REGWIN_SIZE_LOG2) == (regwin_base >> REGWIN_SIZE_LOG2);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register port answer: rdata is forced to zero between reads so that a
   // host sampling late sees nothing stale.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata  <= 8'h00;
         rd_hit <= 1'b0;
      end else begin
         rdata  <= data_rd ? rdata_nxt : 8'h00;
         rd_hit <= data_rd && idx_known;
      end
   end

   // Host cycle claims. Both may claim when bases overlap; software picks the
   // space through the enable bits, the hardware does not arbitrate.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         claim_gfx    <= 1'b0;
         claim_regwin <= 1'b0;
      end else begin
         claim_gfx    <= mem_cycle && in_gfx && resp_en_r[`GFX_EN_BIT];
         claim_regwin <= mem_cycle && in_regwin && resp_en_r[`REGWIN_EN_BIT];
      end
   end

   // Mode status for the rest of the chip, one cycle behind the register.
   // It moves in step with the claims, which see the same register value.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         map_linear     <= 1'b0;
         aper_log2_256k <= 4'h0;
      end else begin
         map_linear     <= map_ctrl_r[`MAP_EN_BIT];
         aper_log2_256k <= map_ctrl_r[`MAP_EN_BIT] ? {1'b0, size_code} : 4'h0;
      end
   end

endmodule // memory_aperture_decode

// ===== testbench/host_master.sv
// Host bus master model: indexed register port writes, reads and memory cycles.
// Assumes the bench calls its tasks; all requests change at the falling clock edge.
`timescale 1ns/1ps
module host_master (
   input  wire        clk,                            // bus clock
   input  wire [7:0]  rdata,                          // register read data
   input  wire        rd_hit, claim_gfx, claim_regwin, // answers
   output reg         idx_wr, data_wr, data_rd, mem_cycle, // strobes
   output reg  [7:0]  wdata,                          // port data
   output reg  [23:0] mem_addr                        // host address
);
   initial {idx_wr, data_wr, data_rd, mem_cycle, wdata, mem_addr} = 36'h0;
   task put_idx(input [7:0] i);
      begin @(negedge clk); idx_wr = 1; wdata = i; @(negedge clk); idx_wr = 0; end
   endtask
   // Released data goes to the inverse so that a stale value is never read as fresh.
   task wr(input [7:0] i, input [7:0] v);
      begin put_idx(i); data_wr = 1; wdata = v; @(negedge clk); data_wr = 0; wdata = ~v; end
   endtask
   task rd(input [7:0] i, output [7:0] d, output h);
      begin put_idx(i); data_rd = 1; wdata = ~i; @(negedge clk); data_rd = 0; d = rdata; h = rd_hit; end
   endtask
   task cyc(input [23:0] a, output g, output r);
      begin @(negedge clk); mem_cycle = 1; mem_addr = a; @(negedge clk); mem_cycle = 0;
         mem_addr = ~a; g = claim_gfx; r = claim_regwin; end
   endtask
endmodule // host_master

// ===== testbench/memory_aperture_decode_asserts.sv
// Checker for the aperture decode block; sees only the top module's ports.
`timescale 1ns/1ps
module memory_aperture_decode_asserts #(parameter ADDR_W = 24, parameter REGWIN_SIZE_LOG2 = 16) (
   input wire clk, arst_n, idx_wr, data_wr, data_rd, mem_cycle, rd_hit, // port strobes
   input wire claim_gfx, claim_regwin, map_linear, // decode flags
   input wire [7:0] wdata, rdata, // register data
   input wire [1:0] legacy_sel, // legacy select
   input wire [ADDR_W-1:0] aperture_base, regwin_base, mem_addr, // addresses
   input wire [3:0] aper_log2_256k); // size exponent
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_gfx_needs_cycle: assert property (claim_gfx |-> $past(mem_cycle))
      else $error("graphics claim without cycle");
   a_legacy_window: assert property (claim_gfx && !map_linear |->
      $past(mem_addr) >= 24'h0A0000 && $past(mem_addr) <= 24'h0BFFFF) else $error("legacy range");
   a_linear_window: assert property (claim_gfx && map_linear |->
      (($past(mem_addr) - $past(aperture_base)) >> 18) < (24'h1 << aper_log2_256k))
      else $error("aperture range");
   a_regwin_range: assert property (claim_regwin |-> $past(mem_cycle) &&
      (($past(mem_addr) - $past(regwin_base)) >> REGWIN_SIZE_LOG2) == 0) else $error("regwin range");
   a_size_legacy_zero: assert property (!map_linear |-> aper_log2_256k == 4'h0)
      else $error("size shown in legacy mode");
   a_hit_after_read: assert property (rd_hit |-> $past(data_rd)) else $error("stray hit");
   a_rdata_idle_zero: assert property (!$past(data_rd) |-> rdata == 8'h00)
      else $error("rdata not idle");
   a_reserved_read_zero: assert property (rd_hit |-> (rdata & 8'h22) == 8'h00)
      else $error("reserved bits read");
   c_gfx: cover property (claim_gfx);
   c_regwin: cover property (claim_regwin);
   c_read: cover property (rd_hit);
endmodule // memory_aperture_decode_asserts
bind memory_aperture_decode memory_aperture_decode_asserts #(.ADDR_W(ADDR_W),
   .REGWIN_SIZE_LOG2(REGWIN_SIZE_LOG2)) chk_inst (.*);

// ===== testbench/memory_aperture_decode_bench.sv
// Bench for the aperture decode block, host master model on its bus side.
`timescale 1ns/1ps
module memory_aperture_decode_bench;
   reg clk = 0, arst_n = 0, h, g, r;
   reg [1:0] legacy_sel = 2'h0;
   reg [23:0] aperture_base = 24'h000000, regwin_base = 24'hF00000;
   wire idx_wr, data_wr, data_rd, mem_cycle, rd_hit, claim_gfx, claim_regwin, map_linear;
   wire [7:0] wdata, rdata;
   wire [23:0] mem_addr;
   wire [3:0] aper_log2_256k;
   reg [7:0] d;
   integer miscompares = 0, n_checks = 0, i;
   initial forever #12.5 clk = ~clk;
   memory_aperture_decode memory_aperture_decode_inst (.*);
   host_master host (.*);
   task chk(input [7:0] got, input [7:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", n_checks, miscompares);
         if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   task t_regs;
      begin
         host.rd(8'h14, d, h); chk(d, {7'h0, ~h});
         host.wr(8'h14, 8'hFF); host.rd(8'h14, d, h); chk(d, 8'h1D);
         host.wr(8'h15, 8'hFF); host.rd(8'h15, d, h); chk(d, 8'hC0);
         host.rd(8'h16, d, h); chk(d | {h, 7'h0}, 8'h00);
         $display("t_regs done");
      end
   endtask
   task t_legacy;
      begin
         host.wr(8'h14, 8'h1C); host.wr(8'h15, 8'hC0);
         for (i = 0; i < 4; i = i + 1) begin
            legacy_sel = i[1:0];
            host.cyc(24'h0A0000, g, r); host.cyc(24'h0B8000, h, r);
            chk({6'h0, g, h}, {6'h0, i < 2, i == 0 || i == 3});
            chk({3'h0, map_linear, aper_log2_256k}, 8'h00);
         end
         $display("t_legacy done");
      end
   endtask
   task t_linear;
      begin
         for (i = 0; i < 6; i = i + 1) begin
            host.wr(8'h14, {3'h0, i[2:0], 2'b01});
            @(negedge clk);
            chk({3'h0, map_linear, aper_log2_256k}, {4'h1, i[3:0]});
            host.cyc((24'h040000 << i) - 1, g, r); host.cyc(24'h040000 << i, h, r);
            chk({5'h0, g, h, r}, 8'h04);
         end
         $display("t_linear done");
      end
   endtask
   task t_enable;
      begin
         regwin_base = 24'h000000;
         host.wr(8'h14, 8'h01);
         for (i = 0; i < 4; i = i + 1) begin
            host.wr(8'h15, {i[1:0], 6'h3F});
            host.cyc(24'h001000, g, r); chk({6'h0, r, g}, {6'h0, i[1:0]});
         end
         $display("t_enable done");
      end
   endtask
   initial begin
      #150 arst_n = 1;
      repeat (3) @(negedge clk);
      t_regs; t_legacy; t_linear; t_enable;
      report_and_stop;
   end
   initial begin #50000; miscompares = miscompares + 1; report_and_stop; end
endmodule // memory_aperture_decode_bench
